// File: logic/chs_status_flags.sv
// module: charger status and event-flag register bank behind an AHB-Lite slave
//
// Summary of operation
// - thermistor zone code in bits 2:0: 000,010,011,101,110 as sampled.
// - reserved bits of every status and flag register read as zero.
// - fault status bit 7 follows input over-voltage state.
// - fault status bit 6 follows thermal shutdown state.
// - fault status bit 4 follows safety timer expired state.
// - flags one bit 6 set on input current regulation rising edge.
// - flags one bit 5 set on input voltage regulation rising edge.
// - flags one bit 4 set on die thermal regulation rising edge.
// - flags one bit 3 set on watchdog expired rising edge.
// - flags one bit 0 set whenever charge state code changes.
// - flags two bit 7 set on any power good transition.
// - flags two bit 4 set whenever input source code changes.
// - flags two bit 2 set whenever thermistor zone code changes.
// - flags two bit 1 set whenever optimizer state code changes.
// - flag registers reset to zero, cleared by register reset, not watchdog.
// - fault flags: over-voltage bit 7, shutdown bit 6, timer bit 4.
// - fault flag set on entering over-voltage or thermal shutdown.
// - timer fault flag set on safety timer expired rising edge.
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none

module chs_status_flags #(
    parameter int SYNC_STAGES = 2
) (
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rstn,
    // ahb-lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    // charger state and interrupt
    input  wire chs_pkg::chs_status_t chargerState,
    output logic                     irq
);

    if (SYNC_STAGES < 2 || SYNC_STAGES > 8) begin : g_bad_sync
        $error("SYNC_STAGES must be 2..8");
    end

    // ------------------------------------------------------------
    // input synchroniser and edge history
    // ------------------------------------------------------------
    chs_pkg::chs_status_t syncChain_q [SYNC_STAGES];
    chs_pkg::chs_status_t cur;
    chs_pkg::chs_status_t prev_q;
    logic [3:0]           primeCnt_q;
    logic                 primed;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < SYNC_STAGES; i++) begin
                syncChain_q[i] <= '0;
            end
        end else begin
            syncChain_q[0] <= chargerState;
            for (int i = 1; i < SYNC_STAGES; i++) begin
                syncChain_q[i] <= syncChain_q[i-1];
            end
        end
    end

    assign cur = syncChain_q[SYNC_STAGES-1];

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prev_q <= '0;
        end else begin
            prev_q <= cur;
        end
    end

    // no edges until history holds real samples, else reset looks like an event
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            primeCnt_q <= 4'h0;
        end else if (!primed) begin
            primeCnt_q <= primeCnt_q + 4'h1;
        end
    end

    assign primed = (primeCnt_q == 4'(SYNC_STAGES + 1));

    // ------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------
    logic [7:0] evOne;
    logic [7:0] evTwo;
    logic [7:0] evFault;

    always_comb begin
        evOne   = 8'h00;
        evTwo   = 8'h00;
        evFault = 8'h00;
        if (primed) begin
            evOne[chs_pkg::F1_ICUR_BIT]  = cur.inputCurrentRegulation
                                         & ~prev_q.inputCurrentRegulation;
            evOne[chs_pkg::F1_VIN_BIT]   = cur.inputVoltageRegulation
                                         & ~prev_q.inputVoltageRegulation;
            evOne[chs_pkg::F1_THERM_BIT] = cur.dieThermalRegulation
                                         & ~prev_q.dieThermalRegulation;
            evOne[chs_pkg::F1_WDOG_BIT]  = cur.watchdogExpiredStatus
                                         & ~prev_q.watchdogExpiredStatus;
            evOne[chs_pkg::F1_CHARGE_BIT] = cur.chargeStateCode
                                         != prev_q.chargeStateCode;
            evTwo[chs_pkg::F2_PGOOD_BIT] = cur.powerGoodSignal
                                         ^ prev_q.powerGoodSignal;
            evTwo[chs_pkg::F2_INPUT_BIT] = cur.inputSourceCode
                                         != prev_q.inputSourceCode;
            evTwo[chs_pkg::F2_ZONE_BIT]  = cur.thermistorZoneCode
                                         != prev_q.thermistorZoneCode;
            evTwo[chs_pkg::F2_ICO_BIT]   = cur.currentOptimizerState
                                         != prev_q.currentOptimizerState;
            evFault[chs_pkg::FAULT_OVP_BIT]   = cur.inputOvervoltageState
                                              & ~prev_q.inputOvervoltageState;
            evFault[chs_pkg::FAULT_TSHUT_BIT] = cur.thermalShutdownState
                                              & ~prev_q.thermalShutdownState;
            evFault[chs_pkg::FAULT_TIMER_BIT] = cur.safetyTimerExpiredState
                                              & ~prev_q.safetyTimerExpiredState;
        end
    end

    // ------------------------------------------------------------
    // live status registers
    // ------------------------------------------------------------
    logic [7:0] zoneStatus;
    logic [7:0] faultStatus;

    assign zoneStatus = {5'h00, cur.thermistorZoneCode};

    always_comb begin
        faultStatus = 8'h00;
        faultStatus[chs_pkg::FAULT_OVP_BIT]   = cur.inputOvervoltageState;
        faultStatus[chs_pkg::FAULT_TSHUT_BIT] = cur.thermalShutdownState;
        faultStatus[chs_pkg::FAULT_TIMER_BIT] = cur.safetyTimerExpiredState;
    end

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic       addrPhase;
    logic       mapped;
    logic [7:0] addrIdx;
    logic       rdAccept;
    logic       wrPend_q;
    logic [7:0] wrIdx_q;
    logic       regRst;

    assign addrPhase = hsel & hready & htrans[1];
    assign addrIdx   = haddr[9:2];
    assign mapped    = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
    assign rdAccept  = addrPhase & ~hwrite & mapped;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wrPend_q <= 1'b0;
            wrIdx_q  <= 8'h00;
        end else begin
            wrPend_q <= addrPhase & hwrite & mapped;
            wrIdx_q  <= addrIdx;
        end
    end

    assign regRst = wrPend_q && (wrIdx_q == chs_pkg::IDX_CONTROL)
                    && hwdata[chs_pkg::CTRL_REGRST_BIT];

    // ------------------------------------------------------------
    // event flag registers
    // ------------------------------------------------------------
    logic [7:0] flagsOne_q;
    logic [7:0] flagsTwo_q;
    logic [7:0] faultFlags_q;
    logic       clrOne;
    logic       clrTwo;
    logic       clrFault;

    // read clears; an event in the same cycle survives into the next read
    assign clrOne   = regRst | (rdAccept && addrIdx == chs_pkg::IDX_FLAGS_ONE);
    assign clrTwo   = regRst | (rdAccept && addrIdx == chs_pkg::IDX_FLAGS_TWO);
    assign clrFault = regRst | (rdAccept && addrIdx == chs_pkg::IDX_FAULT_FLAGS);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            flagsOne_q   <= chs_pkg::FLAGS_RESET;
            flagsTwo_q   <= chs_pkg::FLAGS_RESET;
            faultFlags_q <= chs_pkg::FLAGS_RESET;
        end else begin
            flagsOne_q   <= (clrOne ? 8'h00 : flagsOne_q) | evOne;
            flagsTwo_q   <= (clrTwo ? 8'h00 : flagsTwo_q) | evTwo;
            faultFlags_q <= (clrFault ? 8'h00 : faultFlags_q) | evFault;
        end
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    logic [23:0] intStatus_q;
    logic [23:0] intMask_q;
    logic [23:0] intClr;
    logic        irq_q;

    assign intClr = (wrPend_q && wrIdx_q == chs_pkg::IDX_INT_STATUS) ? hwdata[23:0] : 24'h000000;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            intStatus_q <= chs_pkg::INT_STATUS_RESET;
        end else if (regRst) begin
            intStatus_q <= {evFault, evTwo, evOne};
        end else begin
            intStatus_q <= (intStatus_q & ~intClr) | {evFault, evTwo, evOne};
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            intMask_q <= chs_pkg::INT_MASK_RESET;
        end else if (regRst) begin
            intMask_q <= chs_pkg::INT_MASK_RESET;
        end else if (wrPend_q && wrIdx_q == chs_pkg::IDX_INT_MASK) begin
            intMask_q <= hwdata[23:0] & chs_pkg::INT_VALID;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(intStatus_q & intMask_q);
        end
    end

    assign irq = irq_q;

    // ------------------------------------------------------------
    // read data and response
    // ------------------------------------------------------------
    logic [31:0] rdMux;
    logic [31:0] hrdata_q;
    logic        hreadyout_q;

    always_comb begin
        rdMux = 32'h00000000;
        if (mapped) begin
            unique case (addrIdx)
                chs_pkg::IDX_ZONE_STATUS:  rdMux = {24'h000000, zoneStatus};
                chs_pkg::IDX_FAULT_STATUS: rdMux = {24'h000000, faultStatus};
                chs_pkg::IDX_FLAGS_ONE:    rdMux = {24'h000000, flagsOne_q};
                chs_pkg::IDX_FLAGS_TWO:    rdMux = {24'h000000, flagsTwo_q};
                chs_pkg::IDX_FAULT_FLAGS:  rdMux = {24'h000000, faultFlags_q};
                chs_pkg::IDX_INT_STATUS:   rdMux = {8'h00, intStatus_q};
                chs_pkg::IDX_INT_MASK:     rdMux = {8'h00, intMask_q};
                default:                   rdMux = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hrdata_q    <= 32'h00000000;
            hreadyout_q <= 1'b0;
        end else begin
            hrdata_q    <= (addrPhase & ~hwrite) ? rdMux : 32'h00000000;
            hreadyout_q <= 1'b1;
        end
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp     = 1'b0;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    zone_read_a: assert property (rdAccept && addrIdx == chs_pkg::IDX_ZONE_STATUS
        |=> hrdata[31:3] == 29'h0 && hrdata[2:0] == $past(cur.thermistorZoneCode))
        else $error("zone read mismatch");

    fault_read_a: assert property (rdAccept && addrIdx == chs_pkg::IDX_FAULT_STATUS
        |=> hrdata[7] == $past(cur.inputOvervoltageState)
            && hrdata[6] == $past(cur.thermalShutdownState)
            && hrdata[4] == $past(cur.safetyTimerExpiredState)
            && hrdata[5] == 1'b0 && hrdata[3:0] == 4'h0)
        else $error("fault status read mismatch");

    reserved_zero_a: assert property ((flagsOne_q & ~chs_pkg::FLAGS_ONE_VALID) == 8'h00
        && (flagsTwo_q & ~chs_pkg::FLAGS_TWO_VALID) == 8'h00
        && (faultFlags_q & ~chs_pkg::FAULT_FLAG_VALID) == 8'h00)
        else $error("reserved flag bit set");

    icur_rise_a: assert property (primed && $rose(cur.inputCurrentRegulation)
        |=> flagsOne_q[chs_pkg::F1_ICUR_BIT])
        else $error("current regulation edge not flagged");

    charge_change_a: assert property (primed && cur.chargeStateCode != $past(cur.chargeStateCode)
        ##1 1'b1 |-> flagsOne_q[chs_pkg::F1_CHARGE_BIT])
        else $error("charge change not flagged");

    pgood_toggle_a: assert property (primed && $changed(cur.powerGoodSignal)
        |=> flagsTwo_q[chs_pkg::F2_PGOOD_BIT])
        else $error("power good toggle not flagged");

    ovp_enter_a: assert property (primed && $rose(cur.inputOvervoltageState)
        |=> faultFlags_q[chs_pkg::FAULT_OVP_BIT] [*1] ##0 1'b1)
        else $error("over-voltage entry not flagged");

    read_clear_a: assert property (rdAccept && addrIdx == chs_pkg::IDX_FLAGS_TWO
        |=> flagsTwo_q == $past(evTwo))
        else $error("flags two not cleared by read");

    flag_hold_a: assert property (flagsOne_q[chs_pkg::F1_WDOG_BIT] && !clrOne
        |=> flagsOne_q[chs_pkg::F1_WDOG_BIT])
        else $error("watchdog flag lost without read");

    reg_reset_a: assert property (regRst
        |=> faultFlags_q == $past(evFault) && flagsOne_q == $past(evOne))
        else $error("register reset did not clear flags");

    irq_level_a: assert property ((intStatus_q & intMask_q) != 24'h0 ##1
        (intStatus_q & intMask_q) != 24'h0 |-> irq)
        else $error("irq low with pending unmasked event");

    vin_rise_a: assert property (primed && $rose(cur.inputVoltageRegulation)
        |=> flagsOne_q[chs_pkg::F1_VIN_BIT])
        else $error("voltage regulation edge not flagged");

    therm_rise_a: assert property (primed && $rose(cur.dieThermalRegulation)
        |=> flagsOne_q[chs_pkg::F1_THERM_BIT])
        else $error("thermal regulation edge not flagged");

    wdog_rise_a: assert property (primed && $rose(cur.watchdogExpiredStatus)
        |=> flagsOne_q[chs_pkg::F1_WDOG_BIT])
        else $error("watchdog edge not flagged");

    input_change_a: assert property (primed && $changed(cur.inputSourceCode)
        |=> flagsTwo_q[chs_pkg::F2_INPUT_BIT])
        else $error("input source change not flagged");

    zone_change_a: assert property (primed && $changed(cur.thermistorZoneCode)
        |=> flagsTwo_q[chs_pkg::F2_ZONE_BIT])
        else $error("zone change not flagged");

    ico_change_a: assert property (primed && $changed(cur.currentOptimizerState)
        |=> flagsTwo_q[chs_pkg::F2_ICO_BIT])
        else $error("optimizer change not flagged");

    tshut_enter_a: assert property (primed && $rose(cur.thermalShutdownState)
        |=> faultFlags_q[chs_pkg::FAULT_TSHUT_BIT])
        else $error("thermal shutdown entry not flagged");

    timer_rise_a: assert property (primed && $rose(cur.safetyTimerExpiredState)
        |=> faultFlags_q[chs_pkg::FAULT_TIMER_BIT])
        else $error("safety timer edge not flagged");

endmodule : chs_status_flags

`default_nettype wire

// File: shared/chs_pkg.sv
// package: register map, field positions and carrier types of the charger status/flag bank
package chs_pkg;

    // ------------------------------------------------------------
    // register indexes (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_ZONE_STATUS  = 8'h0D;
    localparam logic [7:0] IDX_FAULT_STATUS = 8'h0E;
    localparam logic [7:0] IDX_FLAGS_ONE    = 8'h0F;
    localparam logic [7:0] IDX_FLAGS_TWO    = 8'h10;
    localparam logic [7:0] IDX_FAULT_FLAGS  = 8'h11;
    localparam logic [7:0] IDX_INT_STATUS   = 8'h18;
    localparam logic [7:0] IDX_INT_MASK     = 8'h19;
    localparam logic [7:0] IDX_CONTROL      = 8'h1A;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FAULT_OVP_BIT   = 7;
    localparam int FAULT_TSHUT_BIT = 6;
    localparam int FAULT_TIMER_BIT = 4;
    localparam int F1_ICUR_BIT     = 6;
    localparam int F1_VIN_BIT      = 5;
    localparam int F1_THERM_BIT    = 4;
    localparam int F1_WDOG_BIT     = 3;
    localparam int F1_CHARGE_BIT   = 0;
    localparam int F2_PGOOD_BIT    = 7;
    localparam int F2_INPUT_BIT    = 4;
    localparam int F2_ZONE_BIT     = 2;
    localparam int F2_ICO_BIT      = 1;
    localparam int CTRL_REGRST_BIT = 0;

    // ------------------------------------------------------------
    // implemented-bit masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  FLAGS_ONE_VALID   = 8'h79;
    localparam logic [7:0]  FLAGS_TWO_VALID   = 8'h96;
    localparam logic [7:0]  FAULT_FLAG_VALID  = 8'hD0;
    localparam logic [23:0] INT_VALID         = {FAULT_FLAG_VALID, FLAGS_TWO_VALID,
                                                 FLAGS_ONE_VALID};
    localparam logic [7:0]  FLAGS_RESET       = 8'h00;
    localparam logic [23:0] INT_STATUS_RESET  = 24'h000000;
    localparam logic [23:0] INT_MASK_RESET    = 24'h000000;

    // ------------------------------------------------------------
    // carrier: live charger state from the analog side
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] thermistorZoneCode;
        logic       inputOvervoltageState;
        logic       thermalShutdownState;
        logic       safetyTimerExpiredState;
        logic       inputCurrentRegulation;
        logic       inputVoltageRegulation;
        logic       dieThermalRegulation;
        logic       watchdogExpiredStatus;
        logic [2:0] chargeStateCode;
        logic       powerGoodSignal;
        logic [2:0] inputSourceCode;
        logic [1:0] currentOptimizerState;
    } chs_status_t;

endpackage : chs_pkg

// File: tb/chs_host_model.sv
// partner: ahb-lite host issuing single whole-word transfers to the flag bank
`timescale 1ns/10ps
`default_nettype none

module chs_host_model (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // ahb-lite master side
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h00000000;
    end

    // index is turned into the byte address; no wait count assumed, only hready
    task automatic xfer(input logic [7:0] idx, input logic wr, input logic [31:0] wdata,
                        output logic [31:0] rdata);
        if (rstn !== 1'b1) begin
            @(posedge rstn);
        end
        @(posedge ref_clk);
        hsel   <= 1'b1;
        haddr  <= {22'h000000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge ref_clk);
        while (hready !== 1'b1) begin
            @(posedge ref_clk);
        end
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wdata;
        @(posedge ref_clk);
        while (hready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rdata = hrdata;
        // stale write data is not left looking valid
        hwdata <= ~wdata;
    endtask : xfer
endmodule : chs_host_model

`default_nettype wire

// File: tb/tb_chs_status_flags.sv
// testbench: charger status and event-flag bank driven by the host model
`timescale 1ns/10ps
`default_nettype none

module tb_chs_status_flags;
    localparam int SYNC = 3;

    logic                 ref_clk;
    logic                 rstn;
    logic                 hsel;
    logic [31:0]          haddr;
    logic [1:0]           htrans;
    logic                 hwrite;
    logic [2:0]           hsize;
    logic [31:0]          hwdata;
    logic [31:0]          hrdata;
    logic                 hreadyout;
    logic                 hresp;
    logic                 irq;
    chs_pkg::chs_status_t st;
    int                   num_errors;
    int                   compares;

    chs_status_flags #(.SYNC_STAGES(SYNC)) dut (
        .ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .chargerState(st), .irq(irq));

    chs_host_model host (
        .ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

    initial begin
        ref_clk = 1'b0;
        rstn = 1'b0;
        st = '0;
        num_errors = 0;
        compares = 0;
    end

    always #12.5 ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string name);
        logic [31:0] d;
        host.xfer(idx, 1'b0, 32'h00000000, d);
        chk(name, exp, d);
        chk("hresp", 32'h00000000, {31'h0, hresp});
    endtask : rd_chk

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] unused;
        host.xfer(idx, 1'b1, d, unused);
    endtask : wr

    // change lands in the flags after SYNC+1 edges
    task automatic apply(input chs_pkg::chs_status_t s);
        @(posedge ref_clk);
        st <= s;
        repeat (SYNC + 2) @(posedge ref_clk);
    endtask : apply

    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("irq", {31'h0, exp}, {31'h0, irq});
    endtask : irq_chk

    function automatic logic [31:0] bitv(input int b);
        return 32'h00000001 << b;
    endfunction : bitv

    function automatic chs_pkg::chs_status_t with_bit(input chs_pkg::chs_status_t s,
                                                      input int k, input logic v);
        chs_pkg::chs_status_t r;
        r = s;
        case (k)
            0: r.inputOvervoltageState = v;
            1: r.thermalShutdownState = v;
            2: r.safetyTimerExpiredState = v;
            3: r.inputCurrentRegulation = v;
            4: r.inputVoltageRegulation = v;
            5: r.dieThermalRegulation = v;
            default: r.watchdogExpiredStatus = v;
        endcase
        return r;
    endfunction : with_bit

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rd_chk(chs_pkg::IDX_ZONE_STATUS, 32'h0, "zone_status");
        rd_chk(chs_pkg::IDX_FAULT_STATUS, 32'h0, "fault_status");
        rd_chk(chs_pkg::IDX_FLAGS_ONE, 32'h0, "flags_one");
        rd_chk(chs_pkg::IDX_FLAGS_TWO, 32'h0, "flags_two");
        rd_chk(chs_pkg::IDX_FAULT_FLAGS, 32'h0, "fault_flags");
        rd_chk(chs_pkg::IDX_INT_MASK, 32'h0, "int_mask");
    endtask : t_reset

    task automatic t_zone;
        logic [2:0]           codes [5];
        chs_pkg::chs_status_t s;
        codes = '{3'h2, 3'h3, 3'h5, 3'h6, 3'h0};
        for (int i = 0; i < 5; i++) begin
            s = st;
            s.thermistorZoneCode = codes[i];
            apply(s);
            rd_chk(chs_pkg::IDX_ZONE_STATUS, {29'h0, codes[i]}, "zone_status");
            rd_chk(chs_pkg::IDX_FLAGS_TWO, bitv(chs_pkg::F2_ZONE_BIT), "zone_flag");
            rd_chk(chs_pkg::IDX_FLAGS_TWO, 32'h0, "zone_flag_cleared");
        end
    endtask : t_zone

    // fault levels and rising-edge flags share one walk: set, read twice, drop
    task automatic t_edges;
        int         ebit [7];
        logic [7:0] fidx;
        ebit = '{chs_pkg::FAULT_OVP_BIT, chs_pkg::FAULT_TSHUT_BIT, chs_pkg::FAULT_TIMER_BIT,
                 chs_pkg::F1_ICUR_BIT, chs_pkg::F1_VIN_BIT, chs_pkg::F1_THERM_BIT,
                 chs_pkg::F1_WDOG_BIT};
        for (int k = 0; k < 7; k++) begin
            fidx = (k < 3) ? chs_pkg::IDX_FAULT_FLAGS : chs_pkg::IDX_FLAGS_ONE;
            apply(with_bit(st, k, 1'b1));
            if (k < 3) begin
                rd_chk(chs_pkg::IDX_FAULT_STATUS, bitv(ebit[k]), "fault_status");
            end
            rd_chk(fidx, bitv(ebit[k]), "edge_flag");
            rd_chk(fidx, 32'h0, "edge_flag_cleared");
            apply(with_bit(st, k, 1'b0));
            rd_chk(fidx, 32'h0, "edge_flag_falling");
            if (k < 3) begin
                rd_chk(chs_pkg::IDX_FAULT_STATUS, 32'h0, "fault_status_low");
            end
        end
    endtask : t_edges

    task automatic t_changes;
        chs_pkg::chs_status_t s;
        s = st;
        s.chargeStateCode = 3'h3;
        apply(s);
        rd_chk(chs_pkg::IDX_FLAGS_ONE, bitv(chs_pkg::F1_CHARGE_BIT), "charge_flag");
        s.chargeStateCode = 3'h6;
        apply(s);
        rd_chk(chs_pkg::IDX_FLAGS_ONE, bitv(chs_pkg::F1_CHARGE_BIT), "charge_flag2");
        for (int i = 0; i < 2; i++) begin
            s.powerGoodSignal = ~s.powerGoodSignal;
            apply(s);
            rd_chk(chs_pkg::IDX_FLAGS_TWO, bitv(chs_pkg::F2_PGOOD_BIT), "pgood_flag");
        end
        s.inputSourceCode = 3'h5;
        s.currentOptimizerState = 2'h2;
        apply(s);
        // a write to the read-only flag register must not disturb it
        wr(chs_pkg::IDX_FLAGS_TWO, 32'hFFFFFFFF);
        rd_chk(chs_pkg::IDX_FLAGS_TWO, bitv(chs_pkg::F2_INPUT_BIT) | bitv(chs_pkg::F2_ICO_BIT),
               "input_ico_flags");
        s.currentOptimizerState = 2'h1;
        apply(s);
        rd_chk(chs_pkg::IDX_FLAGS_TWO, bitv(chs_pkg::F2_ICO_BIT), "current_optimizer_change_event");
    endtask : t_changes

    task automatic t_irq_regrst;
        // drop events latched by earlier scenarios before judging irq
        wr(chs_pkg::IDX_INT_STATUS, 32'h00FFFFFF);
        wr(chs_pkg::IDX_INT_MASK, bitv(chs_pkg::F1_ICUR_BIT));
        apply(with_bit(st, 4, 1'b1));
        irq_chk(1'b0);
        rd_chk(chs_pkg::IDX_INT_STATUS, bitv(chs_pkg::F1_VIN_BIT), "int_status");
        apply(with_bit(st, 3, 1'b1));
        irq_chk(1'b1);
        wr(chs_pkg::IDX_INT_STATUS, bitv(chs_pkg::F1_ICUR_BIT));
        irq_chk(1'b0);
        wr(chs_pkg::IDX_CONTROL, bitv(chs_pkg::CTRL_REGRST_BIT));
        rd_chk(chs_pkg::IDX_FLAGS_ONE, 32'h0, "flags_one_regrst");
        rd_chk(chs_pkg::IDX_INT_STATUS, 32'h0, "int_status_regrst");
        rd_chk(chs_pkg::IDX_INT_MASK, 32'h0, "int_mask_regrst");
        rd_chk(8'h30, 32'h0, "unmapped");
    endtask : t_irq_regrst

    task automatic print_verdict;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (SYNC + 3) @(posedge ref_clk);
        t_reset();
        t_zone();
        t_edges();
        t_changes();
        t_irq_regrst();
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        print_verdict();
    end
endmodule : tb_chs_status_flags

`default_nettype wire
